// *** hw/delta_freeze_reg.sv ***
// Purpose: holds the 16-bit frequency-delta readout with freeze and clear
// Assumes: measurement word arrives with a one-cycle valid strobe
// Notes:   clear beats both freeze and a fresh sample
`include "ref_bank_defines.svh"
`default_nettype none
module delta_freeze_reg
    import ref_bank_pkg::*;
#(
    parameter int DELTA_W = 16
)(
    input  wire logic               ref_clk,
    input  wire logic               srst,
    input  wire logic [DELTA_W-1:0] meas_delta,
    input  wire logic               meas_valid,
    input  wire logic               freeze,
    input  wire logic               clear,
    output logic      [DELTA_W-1:0] delta
);
    // the readout is split over exactly two bytes
    if (DELTA_W != 16)
    begin : g_bad_width
        $error("delta_freeze_reg: width must be 16");
    end

    logic [DELTA_W-1:0] next_delta; // value for next edge

    // next-value selection
    always_comb
    begin
        next_delta = delta;
        if (clear)
        begin
            next_delta = '0;
        end
        else if (meas_valid && !freeze)
        begin
            next_delta = meas_delta;
        end
    end

    // registering only
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            delta <= '0;
        else
            delta <= next_delta;
    end
endmodule : delta_freeze_reg
`default_nettype wire

// *** hw/read_data_reg.sv ***
// Purpose: registered read-data stage for the byte bank
// Assumes: selected byte is valid in the cycle of the load strobe
// Notes:   keeps the top module's read output straight from a flop
`default_nettype none
module read_data_reg #(
    parameter int W = 8
)(
    input  wire logic         ref_clk,
    input  wire logic         srst,
    input  wire logic         load,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    // a zero-width stage has nothing to hold
    if (W < 1)
    begin : g_bad_width
        $error("read_data_reg: width must be positive");
    end

    logic [W-1:0] next_dout; // held unless loaded

    // hold or load
    always_comb
    begin
        next_dout = load ? din : dout;
    end

    // registering only
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            dout <= '0;
        else
            dout <= next_dout;
    end
endmodule : read_data_reg
`default_nettype wire

// *** hw/ref_bank_defines.svh ***
// Purpose: offsets, field positions, reset values and counts of the reference/spread bank
// Assumes: byte-wide registers reached by index from the serial target engine
// Notes:   definitions only
`ifndef REF_BANK_DEFINES_SVH
`define REF_BANK_DEFINES_SVH

// byte indices
`define IDX_REF_CTRL        8'h03
`define IDX_DELTA_LOW       8'h04
`define IDX_DELTA_HIGH      8'h05
`define IDX_SPREAD_CTRL     8'h06
`define IDX_REV_VENDOR      8'h08
`define IDX_DEVICE_IDENT    8'h09
`define IDX_BYTE_COUNT      8'h0a
`define IDX_LAST            8'h10

// reference control byte fields
`define REF_LOST_BIT        7
`define REF_FREEZE_BIT      6
`define REF_CLEAR_BIT       5

// spread control byte fields
`define SPR_PIN_HI          5
`define SPR_PIN_LO          4
`define SPR_SRC_BIT         3
`define SPR_SW_BIT          2
`define SPR_SEL_HI          1
`define SPR_SEL_LO          0

// reset values
`define BYTE_COUNT_RESET    6'h08
`define SPREAD_OFF_CODE     2'h0

`endif

// *** hw/ref_bank_pkg.sv ***
// Purpose: shared types of the reference/spread bank
// Assumes: nothing beyond the defines header
// Notes:   block-read sequencer states are one-hot
`default_nettype none
package ref_bank_pkg;
    // block-read sequencer states
    typedef enum logic [2:0] {
        BR_IDLE  = 3'b001,
        BR_COUNT = 3'b010,
        BR_DATA  = 3'b100
    } block_read_state_t;
endpackage : ref_bank_pkg
`default_nettype wire

// *** hw/ref_delta_ssc_id_register_bank.sv ***
// Purpose: reference-input, frequency-delta, spread and identification byte bank
// Assumes: a serial target engine outside presents byte index, write and read strobes
// Notes:   block reads return the byte count first, then bytes from the start index
//          the delta word is stored as measured; its sign encoding is the measurer's
//          the spread pin is caught once, on the first edge after reset
//          a new start before the count byte simply restarts the read
//          indices past the top wrap through the reserved bytes and read zero
//
// Contract
// - ref control bit7 reads live lost pin
// - freeze bit6 stops both delta bytes updating
// - writing clear bit5 zeroes both delta bytes
// - delta bytes show average ppm difference
// - high byte bit7 is the sign
// - spread bits 5:4 read back enable pin
// - spread bit3 selects crystal or filter PLL
// - bit2 pin/software; bits1:0 latch pin at reset
// - index 8 read-only revision and vendor
// - index 9 read-only device ident
// - byte count bits5:0 rw, reset 001000
// - block read: count first, then data bytes
`include "ref_bank_defines.svh"
`default_nettype none
module ref_delta_ssc_id_register_bank
    import ref_bank_pkg::*;
#(
    parameter logic [3:0] REVISION_CODE = 4'h0,  // arbitrary value
    parameter logic [3:0] VENDOR_CODE   = 4'h5,  // arbitrary value
    parameter logic [7:0] DEVICE_CODE   = 8'h5a  // arbitrary value
)(
    input  wire logic        ref_clk,
    input  wire logic        srst,
    // byte access from the serial target engine
    input  wire logic [7:0]  byte_index,
    input  wire logic        byte_write,
    input  wire logic [7:0]  byte_wdata,
    input  wire logic        block_read_start,
    input  wire logic        byte_read,
    output logic      [7:0]  byte_rdata,
    output logic             rdata_valid,
    // pins and measurement
    input  wire logic        ref_input_lost_n,
    input  wire logic [1:0]  spread_enable_pin,
    input  wire logic [15:0] meas_delta,
    input  wire logic        meas_valid,
    // spread PLL controls
    output logic             spread_src_filter_pll,
    output logic [1:0]       spread_amount
);
    // software-visible state, plus the internal strap_taken flag
    logic        freeze;          // delta update stop
    logic        clear_pend;      // delta clear in flight
    logic        spread_src;      // spread PLL input select
    logic        spread_sw;       // software owns amount
    logic [1:0]  spread_sel;      // software amount code
    logic [5:0]  byte_count;      // block-read length
    logic        strap_taken;     // pin latched after reset
    logic [15:0] delta;           // held readout
    // next values of the state above
    logic        next_freeze;
    logic        next_clear_pend;
    logic        next_spread_src;
    logic        next_spread_sw;
    logic [1:0]  next_spread_sel;
    logic [5:0]  next_byte_count;
    logic        next_strap_taken;

    // block-read sequencer
    block_read_state_t br_state;
    block_read_state_t next_br_state;
    logic [7:0]  cur_index;       // next byte to return
    logic [7:0]  next_cur_index;
    logic [7:0]  rd_sel;          // byte chosen for read stage
    logic        rd_load;         // load read stage
    // next values of the output flops
    logic        next_rdata_valid;
    logic        next_spread_src_out;
    logic [1:0]  next_spread_amount;

    // write hits the index in this cycle
    function automatic logic hit(input logic [7:0] idx);
        hit = byte_write && (byte_index == idx);
    endfunction : hit

    // read mux; unmapped and reserved indices return zero
    function automatic logic [7:0] read_byte(input logic [7:0] idx);
        logic [7:0] v;
        v = 8'h00;
        // one byte per index; bits not listed stay zero
        case (idx)
            `IDX_REF_CTRL:
            begin
                v[`REF_LOST_BIT]   = ref_input_lost_n;
                v[`REF_FREEZE_BIT] = freeze;
                v[`REF_CLEAR_BIT]  = clear_pend;
            end
            `IDX_DELTA_LOW:    v = delta[7:0];
            `IDX_DELTA_HIGH:   v = delta[15:8];
            `IDX_SPREAD_CTRL:
            begin
                v[`SPR_PIN_HI:`SPR_PIN_LO] = spread_enable_pin;
                v[`SPR_SRC_BIT] = spread_src;
                v[`SPR_SW_BIT]  = spread_sw;
                v[`SPR_SEL_HI:`SPR_SEL_LO] = spread_sel;
            end
            `IDX_REV_VENDOR:   v = {REVISION_CODE, VENDOR_CODE};
            `IDX_DEVICE_IDENT: v = DEVICE_CODE;
            `IDX_BYTE_COUNT:   v = {2'h0, byte_count};
            default:           v = 8'h00;
        endcase
        read_byte = v;
    endfunction : read_byte

    // the index map must keep the byte count below the reserved top index
    if (`IDX_BYTE_COUNT >= `IDX_LAST)
    begin : g_bad_index_map
        $error("ref_delta_ssc_id_register_bank: index map out of order");
    end

    // delta holder: clear pulse from the pending bit zeroes it
    // freeze only blocks samples, so a clear still zeroes a frozen readout
    delta_freeze_reg #(
        .DELTA_W (16)
    ) u_delta (
        .ref_clk    (ref_clk),
        .srst       (srst),
        .meas_delta (meas_delta),
        .meas_valid (meas_valid),
        .freeze     (freeze),
        .clear      (clear_pend),
        .delta      (delta)
    );

    // control register next values
    always_comb
    begin
        next_freeze      = freeze;
        next_spread_src  = spread_src;
        next_spread_sw   = spread_sw;
        next_spread_sel  = spread_sel;
        next_byte_count  = byte_count;
        next_strap_taken = 1'b1;
        // clear acts for one cycle then reads back 0
        next_clear_pend  = 1'b0;
        if (!strap_taken)
        begin
            // first cycle after reset: catch the pin as the amount code
            next_spread_sel = spread_enable_pin;
        end
        if (hit(`IDX_REF_CTRL))
        begin
            next_freeze     = byte_wdata[`REF_FREEZE_BIT];
            next_clear_pend = byte_wdata[`REF_CLEAR_BIT];
        end
        if (hit(`IDX_SPREAD_CTRL))
        begin
            next_spread_src = byte_wdata[`SPR_SRC_BIT];
            next_spread_sw  = byte_wdata[`SPR_SW_BIT];
            next_spread_sel = byte_wdata[`SPR_SEL_HI:`SPR_SEL_LO];
        end
        // writes to read-only or reserved indices match no branch and are lost
        if (hit(`IDX_BYTE_COUNT))
        begin
            // reserved top bits dropped
            next_byte_count = byte_wdata[5:0];
        end
    end

    // control registers
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            freeze      <= 1'b0;
            clear_pend  <= 1'b0;
            spread_src  <= 1'b0;
            spread_sw   <= 1'b0;
            spread_sel  <= `SPREAD_OFF_CODE;
            byte_count  <= `BYTE_COUNT_RESET;
            // pin is caught again on the first edge after release
            strap_taken <= 1'b0;
        end
        else
        begin
            freeze      <= next_freeze;
            clear_pend  <= next_clear_pend;
            spread_src  <= next_spread_src;
            spread_sw   <= next_spread_sw;
            spread_sel  <= next_spread_sel;
            byte_count  <= next_byte_count;
            strap_taken <= next_strap_taken;
        end
    end

    // spread control outputs; pin wins until software takes over
    always_comb
    begin
        next_spread_src_out = spread_src;
        if (spread_sw)
        begin
            // software code; a reserved code passes through unchanged
            next_spread_amount = spread_sel;
        end
        else
        begin
            // pin code follows the pin one edge late
            next_spread_amount = spread_enable_pin;
        end
    end

    // block-read sequencer: count byte, then data from start index
    always_comb
    begin
        next_br_state    = br_state;
        next_cur_index   = cur_index;
        rd_sel           = 8'h00;
        rd_load          = 1'b0;
        next_rdata_valid = 1'b0;
        case (br_state)
            BR_IDLE:
            begin
                // byte_read while idle has nothing to answer and is ignored
                if (block_read_start)
                begin
                    // start index latched from byte_index in the same cycle as the start strobe
                    next_cur_index = byte_index;
                    next_br_state  = BR_COUNT;
                end
            end
            BR_COUNT:
            begin
                if (block_read_start)
                begin
                    // a fresh start before the count byte restarts the read
                    next_cur_index = byte_index;
                end
                else if (byte_read)
                begin
                    rd_sel           = {2'h0, byte_count};
                    rd_load          = 1'b1;
                    next_rdata_valid = 1'b1;
                    next_br_state    = BR_DATA;
                end
            end
            BR_DATA:
            begin
                if (block_read_start)
                begin
                    next_cur_index = byte_index;
                    next_br_state  = BR_COUNT;
                end
                else if (byte_read)
                begin
                    rd_sel           = read_byte(cur_index);
                    rd_load          = 1'b1;
                    next_rdata_valid = 1'b1;
                    // wraps naturally past the top index; reserved read zero
                    next_cur_index   = cur_index + 8'h01;
                end
            end
            default:
            begin
                next_br_state = BR_IDLE;
            end
        endcase
    end

    // sequencer and output registers
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            br_state              <= BR_IDLE;
            cur_index             <= 8'h00;
            // no answer stands while in reset
            rdata_valid           <= 1'b0;
            spread_src_filter_pll <= 1'b0;
            spread_amount         <= `SPREAD_OFF_CODE;
        end
        else
        begin
            br_state              <= next_br_state;
            cur_index             <= next_cur_index;
            rdata_valid           <= next_rdata_valid;
            spread_src_filter_pll <= next_spread_src_out;
            spread_amount         <= next_spread_amount;
        end
    end

    // registered read data stage
    read_data_reg #(
        .W (8)
    ) u_rdata (
        .ref_clk (ref_clk),
        .srst    (srst),
        .load    (rd_load),
        .din     (rd_sel),
        .dout    (byte_rdata)
    );
endmodule : ref_delta_ssc_id_register_bank
`default_nettype wire

// *** testbench/ref_bank_props.sv ***
// Purpose: port-level checks of the reference/spread bank
// Assumes: rdata_valid follows each accepted byte_read by one cycle
// Notes:   a small shadow tracks which index a block read is on
`default_nettype none
module ref_bank_props #(
    parameter logic [3:0] REVISION_CODE = 4'h0,
    parameter logic [3:0] VENDOR_CODE   = 4'h5,
    parameter logic [7:0] DEVICE_CODE   = 8'h5a
)(
    input wire logic        ref_clk,
    input wire logic        srst,
    input wire logic [7:0]  byte_index,
    input wire logic        byte_write,
    input wire logic [7:0]  byte_wdata,
    input wire logic        block_read_start,
    input wire logic        byte_read,
    input wire logic [7:0]  byte_rdata,
    input wire logic        rdata_valid,
    input wire logic        ref_input_lost_n,
    input wire logic [1:0]  spread_enable_pin,
    input wire logic [15:0] meas_delta,
    input wire logic        meas_valid,
    input wire logic        spread_src_filter_pll,
    input wire logic [1:0]  spread_amount
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    logic [7:0] rd_idx;      // index of the next data byte
    logic [7:0] next_rd_idx;
    logic       first;       // count byte still to come
    logic       next_first;
    logic [5:0] bc;          // shadow of the byte count
    logic [5:0] next_bc;
    logic [7:0] was_idx;     // index of the byte now answered
    logic       was_first;   // answered byte is the count
    logic       data_v;      // a data byte is on the bus
    assign data_v = rdata_valid && !was_first;
    // shadow of the read pointer and count
    always_comb
    begin
        next_rd_idx = rd_idx;
        next_first  = first;
        next_bc     = bc;
        if (block_read_start)
        begin
            next_rd_idx = byte_index;
            next_first  = 1'b1;
        end
        else if (byte_read)
        begin
            next_first = 1'b0;
            // the count read does not advance the index
            if (!first)
                next_rd_idx = rd_idx + 8'h01;
        end
        if (byte_write && byte_index == 8'h0a)
            next_bc = byte_wdata[5:0];
    end
    // registers only
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            rd_idx    <= 8'h00;
            first     <= 1'b0;
            bc        <= 6'h08;
            was_idx   <= 8'h00;
            was_first <= 1'b0;
        end
        else
        begin
            rd_idx    <= next_rd_idx;
            first     <= next_first;
            bc        <= next_bc;
            was_idx   <= rd_idx;
            was_first <= first;
        end
    end
    property p_cause; rdata_valid |-> $past(byte_read); endproperty
    a_cause: assert property (p_cause) else $error("valid without read");
    property p_count; rdata_valid && was_first |-> byte_rdata == {2'b00, bc}; endproperty
    a_count: assert property (p_count) else $error("bad count byte");
    property p_lost; data_v && was_idx == 8'h03 |->
        byte_rdata[7] == $past(ref_input_lost_n) && byte_rdata[4:0] == 5'h00; endproperty
    a_lost: assert property (p_lost) else $error("bad lost bit");
    property p_resv; data_v && (was_idx inside {8'h07, [8'h0b:8'h10]}) |->
        byte_rdata == 8'h00; endproperty
    a_resv: assert property (p_resv) else $error("reserved byte not zero");
    property p_rev; data_v && was_idx == 8'h08 |->
        byte_rdata == {REVISION_CODE, VENDOR_CODE}; endproperty
    a_rev: assert property (p_rev) else $error("bad revision byte");
    property p_dev; data_v && was_idx == 8'h09 |-> byte_rdata == DEVICE_CODE; endproperty
    a_dev: assert property (p_dev) else $error("bad device byte");
    property p_pin; data_v && was_idx == 8'h06 |->
        byte_rdata[7:4] == {2'b00, $past(spread_enable_pin)}; endproperty
    a_pin: assert property (p_pin) else $error("bad pin readback");
    property p_src; data_v && was_idx == 8'h06 |->
        byte_rdata[3] == spread_src_filter_pll; endproperty
    a_src: assert property (p_src) else $error("bad source select");
    property p_amt; data_v && was_idx == 8'h06 |-> spread_amount ==
        (byte_rdata[2] ? byte_rdata[1:0] : $past(spread_enable_pin)); endproperty
    a_amt: assert property (p_amt) else $error("bad spread amount");
endmodule : ref_bank_props
`default_nettype wire

// *** testbench/ref_delta_ssc_id_register_bank_tb_top.sv ***
// Purpose: self-checking bench of the reference/spread byte bank
// Assumes: host model drives the byte side, bench drives pins
// Notes:   reset image row by row, then hand cases
`default_nettype none
module ref_delta_ssc_id_register_bank_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic        ref_clk = 1'b0; // 20 MHz
    logic        srst = 1'b1;
    logic [7:0]  byte_index, byte_wdata, byte_rdata, d;
    logic        byte_write, block_read_start, byte_read, rdata_valid;
    logic        ref_input_lost_n, meas_valid, spread_src_filter_pll;
    logic [1:0]  spread_enable_pin, spread_amount;
    logic [15:0] meas_delta;
    logic [5:0]  bc = 6'h08; // expected byte count
    int          miscompares = 0;
    int          compares = 0;
    // index beside its byte just after reset, lost pin high, spread pin 01
    localparam logic [15:0] ROWS [14] = '{16'h0380, 16'h0400, 16'h0500, 16'h0611,
        16'h0700, 16'h0805, 16'h095a, 16'h0a08, 16'h0b00, 16'h0c00, 16'h0d00,
        16'h0e00, 16'h0f00, 16'h1000};
    always #25 ref_clk = ~ref_clk;
    ref_delta_ssc_id_register_bank dut_u (.ref_clk(ref_clk), .srst(srst),
        .byte_index(byte_index), .byte_write(byte_write), .byte_wdata(byte_wdata),
        .block_read_start(block_read_start), .byte_read(byte_read),
        .byte_rdata(byte_rdata), .rdata_valid(rdata_valid),
        .ref_input_lost_n(ref_input_lost_n), .spread_enable_pin(spread_enable_pin),
        .meas_delta(meas_delta), .meas_valid(meas_valid),
        .spread_src_filter_pll(spread_src_filter_pll), .spread_amount(spread_amount));
    smbus_host_model host_u (.ref_clk(ref_clk), .byte_index(byte_index),
        .byte_write(byte_write), .byte_wdata(byte_wdata),
        .block_read_start(block_read_start), .byte_read(byte_read),
        .byte_rdata(byte_rdata), .rdata_valid(rdata_valid));
    // byte compare, counted
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // block read of one byte: count comes first
    task automatic chk_at(input logic [7:0] idx, input logic [7:0] exp);
        host_u.op(idx, 8'h00, 1'b0);
        host_u.get(d);
        chk(d, {2'b00, bc});
        host_u.get(d);
        chk(d, exp);
    endtask : chk_at
    // one measurement sample
    task automatic meas(input logic [15:0] v);
        @(posedge ref_clk);
        #2;
        meas_delta = v;
        meas_valid = 1'b1;
        @(posedge ref_clk);
        #2;
        meas_valid = 1'b0;
        meas_delta = ~v;
    endtask : meas
    task automatic end_sim;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    // cut a hang short
    initial
    begin
        #200000;
        miscompares++;
        end_sim();
    end
    initial
    begin
        meas_delta = 16'h0000;
        meas_valid = 1'b0;
        ref_input_lost_n = 1'b1;
        spread_enable_pin = 2'b01;
        repeat (10) @(posedge ref_clk);
        #2;
        srst = 1'b0;
        repeat (2) @(posedge ref_clk);
        for (int i = 0; i < 14; i++)
            chk_at(ROWS[i][15:8], ROWS[i][7:0]);
        chk({6'h00, spread_amount}, 8'h01);
        // software amount 10, filter PLL source
        host_u.op(8'h06, 8'h0e, 1'b1);
        #100;
        chk({7'h00, spread_src_filter_pll}, 8'h01);
        chk({6'h00, spread_amount}, 8'h02);
        chk_at(8'h06, 8'h1e);
        spread_enable_pin = 2'b11;
        chk_at(8'h06, 8'h3e);
        // reserved count bits are dropped
        host_u.op(8'h0a, 8'hff, 1'b1);
        bc = 6'h3f;
        chk_at(8'h0a, 8'h3f);
        // read-only and reserved bytes ignore writes
        host_u.op(8'h08, 8'hff, 1'b1);
        host_u.op(8'h09, 8'h00, 1'b1);
        host_u.op(8'h07, 8'hff, 1'b1);
        chk_at(8'h08, 8'h05);
        chk_at(8'h09, 8'h5a);
        chk_at(8'h07, 8'h00);
        meas(16'h8123);
        chk_at(8'h04, 8'h23);
        chk_at(8'h05, 8'h81);
        host_u.op(8'h03, 8'h40, 1'b1);
        meas(16'h1111);
        chk_at(8'h04, 8'h23);
        chk_at(8'h05, 8'h81);
        chk_at(8'h03, 8'hc0);
        // clear while frozen
        host_u.op(8'h03, 8'h60, 1'b1);
        chk_at(8'h04, 8'h00);
        chk_at(8'h05, 8'h00);
        chk_at(8'h03, 8'hc0);
        host_u.op(8'h03, 8'h00, 1'b1);
        meas(16'h7fff);
        chk_at(8'h04, 8'hff);
        chk_at(8'h05, 8'h7f);
        ref_input_lost_n = 1'b0;
        chk_at(8'h03, 8'h00);
        // mid-run reset: defaults return and the pin is caught again
        srst = 1'b1;
        repeat (3) @(posedge ref_clk);
        #2;
        srst = 1'b0;
        bc = 6'h08;
        repeat (2) @(posedge ref_clk);
        chk_at(8'h0a, 8'h08);
        chk_at(8'h06, 8'h33);
        chk({6'h00, spread_amount}, 8'h03);
        end_sim();
    end
endmodule : ref_delta_ssc_id_register_bank_tb_top
bind ref_delta_ssc_id_register_bank ref_bank_props #(.REVISION_CODE(REVISION_CODE),
    .VENDOR_CODE(VENDOR_CODE), .DEVICE_CODE(DEVICE_CODE)) props_u (.ref_clk(ref_clk),
    .srst(srst), .byte_index(byte_index), .byte_write(byte_write),
    .byte_wdata(byte_wdata), .block_read_start(block_read_start),
    .byte_read(byte_read), .byte_rdata(byte_rdata), .rdata_valid(rdata_valid),
    .ref_input_lost_n(ref_input_lost_n), .spread_enable_pin(spread_enable_pin),
    .meas_delta(meas_delta), .meas_valid(meas_valid),
    .spread_src_filter_pll(spread_src_filter_pll), .spread_amount(spread_amount));
`default_nettype wire

// *** testbench/smbus_host_model.sv ***
// Purpose: host side issuing byte writes and block reads
// Assumes: requests change 2 ns after the rising edge
// Notes:   released index and data lines show the inverse of the last value; strobes drop to 0
`default_nettype none
module smbus_host_model (
    input  wire logic       ref_clk,
    output logic      [7:0] byte_index,
    output logic            byte_write,
    output logic      [7:0] byte_wdata,
    output logic            block_read_start,
    output logic            byte_read,
    input  wire logic [7:0] byte_rdata,
    input  wire logic       rdata_valid
);
    timeunit 1ns;
    timeprecision 100ps;
    // quiet bus at time zero
    initial
    begin
        byte_index       = 8'h00;
        byte_write       = 1'b0;
        byte_wdata       = 8'h00;
        block_read_start = 1'b0;
        byte_read        = 1'b0;
    end
    // one-cycle write (w=1) or beginning index of a read (w=0)
    task automatic op(input logic [7:0] idx, input logic [7:0] dat, input logic w);
        @(posedge ref_clk);
        #2;
        byte_index       = idx;
        byte_wdata       = dat;
        byte_write       = w;
        block_read_start = !w;
        @(posedge ref_clk);
        #2;
        byte_write       = 1'b0;
        block_read_start = 1'b0;
        byte_index       = ~idx;
        byte_wdata       = ~dat;
    endtask : op
    // acknowledged byte; stays x when no answer stands
    task automatic get(output logic [7:0] dat);
        dat = 8'hxx;
        @(posedge ref_clk);
        #2;
        byte_read = 1'b1;
        @(posedge ref_clk);
        #2;
        byte_read = 1'b0;
        if (rdata_valid === 1'b1)
            dat = byte_rdata;
    endtask : get
endmodule : smbus_host_model
`default_nettype wire
